// file: design/sac_control.sv
// Sequencer, register file and analog core control of the converter
//
// Functional notes
// R1: Results kept in sixteen-word memory.
// R2: Result memory is read-only to software.
// R3: Four read-time alignment formats, 16-bit.
// R4: One, two or four channels enabled.
// R5: Count code 00/01/1x selects channels.
// R6: Sequential or simultaneous channel sampling.
// R7: Sample bit shows any channel sampling.
// R8: Writing 1 starts sampling, auto off.
// R9: Writing 0 ends sampling when manual.
// R10: Done set at end, cleared by start.
// R11: Reference select chooses external references.
// R12: Scan steps channel zero positive input.
// R13: Scan mask picks scanned inputs.
// R14: Primary and secondary input settings switch.
// R15: Port configuration sets pins analog/digital.
// R16: Reserved bit 12, bit 11 read 0.
// R17: Interrupt after every N-th sequence.
// R18: Split mode gives two eight-word halves.
// R19: Fill status shows half being filled.
// R20: Alternate mode: primary first, then alternate.
// R21: Strobe core, await done, store result.
`timescale 1ns/1ps
module sac_control (
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  input  wire sac_pkg::sac_bus_req_t      busReq,
  output logic      [sac_pkg::DATA_W-1:0] rdData,
  output sac_pkg::sac_conv_req_t          convReq,
  input  wire sac_pkg::sac_conv_rsp_t     convRsp,
  output logic      [sac_pkg::NUM_CH-1:0] sampleHold,
  output logic                            refHighExt,
  output logic                            refLowExt,
  output logic      [sac_pkg::NUM_PINS-1:0] analogPinMode,
  output logic                            seqIrq
);
  import sac_pkg::*;

  typedef struct packed {
    sac_state_t          state;
    logic [1:0]          chIdx;
    logic [SMP_CNT_W-1:0] smpCnt;
    logic [2:0]          trig;
    logic [1:0]          fmt;
    logic                autoSmp;
    logic                simul;
    logic                done;
    logic [2:0]          refSel;
    logic                scanEn;
    logic [1:0]          chCnt;
    logic [3:0]          ivl;
    logic                split;
    logic                alt;
    logic                fill;
    logic [IN_W-1:0]     primSel;
    logic [IN_W-1:0]     secSel;
    logic [NUM_PINS-1:0] portCfg;
    logic [NUM_PINS-1:0] scanMask;
    logic [IN_W-1:0]     scanPtr;
    logic                altPhase;
    logic [PTR_W-1:0]    wrPtr;
    logic [3:0]          seqCnt;
    logic [DATA_W-1:0]   rdData;
    logic                irq;
    logic [NUM_CH-1:0]   sampling;
    sac_conv_req_t       conv;
  } sac_ctl_state_t;

  sac_ctl_state_t s_r;
  sac_ctl_state_t s_nxt;

  logic [DATA_W-1:0] memWord;
  logic              memWr;
  logic [1:0]        lastCh;
  logic [NUM_CH-1:0] enMask;
  logic              wrOne;
  logic              wrTwo;

  // Next set mask bit after the current pointer, wrapping; stays put on empty mask
  function automatic logic [IN_W-1:0] nextScan(input logic [NUM_PINS-1:0] mask,
                                               input logic [IN_W-1:0] ptr);
    logic [IN_W-1:0] idx;
    logic [IN_W-1:0] res;
    res = ptr;
    for (int i = NUM_PINS - 1; i >= 1; i--) begin
      idx = ptr + IN_W'(i);
      if (mask[idx]) begin
        res = idx;
      end
    end
    return res;
  endfunction

  always_comb begin
    case (s_r.chCnt) // [R4] [R5]
      CHCNT_ONE: lastCh = 2'h0;
      CHCNT_TWO: lastCh = 2'h1;
      default:   lastCh = 2'h3;
    endcase
  end

  // Enable mask from the channel count
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_en
      assign enMask[c] = (2'(c) <= lastCh);
    end
  endgenerate

  assign wrOne = busReq.wr && (busReq.addr == ADDR_CTL_ONE);
  assign wrTwo = busReq.wr && (busReq.addr == ADDR_CTL_TWO);
  assign memWr = (s_r.state == ST_WAIT) && convRsp.done; // [R21]

  always_comb begin
    s_nxt = s_r;
    s_nxt.irq = 1'b0;
    s_nxt.conv.start = 1'b0;

    // Register writes; result memory addresses take no write at all
    if (wrOne) begin
      s_nxt.trig    = busReq.wdata[ONE_TRIG_LSB +: 3];
      s_nxt.fmt     = busReq.wdata[ONE_FMT_LSB +: 2];
      s_nxt.autoSmp = busReq.wdata[ONE_AUTO];
      s_nxt.simul   = busReq.wdata[ONE_SIMUL];
      if (!busReq.wdata[ONE_DONE]) begin
        s_nxt.done = 1'b0; // [R10]
      end
    end
    if (wrTwo) begin
      s_nxt.refSel = busReq.wdata[TWO_REF_LSB +: 3]; // [R11]
      s_nxt.scanEn = busReq.wdata[TWO_SCAN];
      s_nxt.chCnt  = busReq.wdata[TWO_CHCNT_LSB +: 2];
      s_nxt.ivl    = busReq.wdata[TWO_IVL_LSB +: 4];
      s_nxt.split  = busReq.wdata[TWO_SPLIT];
      s_nxt.alt    = busReq.wdata[TWO_ALT];
    end
    if (busReq.wr && busReq.addr == ADDR_CHAN_SEL) begin
      s_nxt.primSel = busReq.wdata[SEL_PRIM_LSB +: IN_W];
      s_nxt.secSel  = busReq.wdata[SEL_SEC_LSB +: IN_W];
    end
    if (busReq.wr && busReq.addr == ADDR_PORT_CFG) begin
      s_nxt.portCfg = busReq.wdata; // [R15]
    end
    if (busReq.wr && busReq.addr == ADDR_SCAN_MASK) begin
      s_nxt.scanMask = busReq.wdata; // [R13]
    end

    case (s_r.state)
      ST_IDLE: begin
        if (s_r.autoSmp || (wrOne && busReq.wdata[ONE_SAMPLE])) begin // [R8]
          s_nxt.state = ST_SAMPLE;
          s_nxt.chIdx = 2'h0;
        end
      end
      ST_SAMPLE: begin
        if (s_r.chIdx != 2'h0) begin
          // Later channels in sequential mode sample for a fixed window
          if (s_r.smpCnt == '0) begin
            s_nxt.state = ST_START;
          end else begin
            s_nxt.smpCnt = s_r.smpCnt - 1'b1;
          end
        end else if (wrOne && !busReq.wdata[ONE_SAMPLE] && s_r.trig == TRIG_MANUAL) begin
          s_nxt.state = ST_START; // [R9]
        end
      end
      ST_START: begin
        s_nxt.conv.start   = 1'b1; // [R21]
        s_nxt.conv.channel = s_r.chIdx;
        if (s_r.chIdx == 2'h0) begin
          s_nxt.done = 1'b0; // [R10]
        end
        s_nxt.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (convRsp.done) begin
          if (s_r.split) begin
            s_nxt.wrPtr = {s_r.fill, 3'(s_r.wrPtr[2:0] + 3'h1)}; // [R18]
          end else begin
            s_nxt.wrPtr = s_r.wrPtr + 1'b1;
          end
          if (s_r.chIdx == lastCh) begin
            s_nxt.done  = 1'b1; // [R10]
            s_nxt.chIdx = 2'h0;
            if (s_r.alt) begin
              s_nxt.altPhase = ~s_r.altPhase; // [R20]
            end
            if (s_r.scanEn && !(s_r.alt && s_r.altPhase)) begin
              s_nxt.scanPtr = nextScan(s_r.scanMask, s_r.scanPtr); // [R12]
            end
            if (s_r.seqCnt == s_r.ivl) begin
              s_nxt.irq    = 1'b1; // [R17]
              s_nxt.seqCnt = 4'h0;
              if (s_r.split) begin
                s_nxt.fill  = ~s_r.fill; // [R19]
                s_nxt.wrPtr = {~s_r.fill, 3'h0};
              end else begin
                s_nxt.wrPtr = '0;
              end
            end else begin
              s_nxt.seqCnt = s_r.seqCnt + 1'b1;
            end
            s_nxt.state = s_r.autoSmp ? ST_SAMPLE : ST_IDLE;
          end else begin
            s_nxt.chIdx  = s_r.chIdx + 1'b1;
            s_nxt.smpCnt = SMP_CNT_W'(SEQ_SAMPLE_CYC - 1);
            // Simultaneous channels already hold; convert straight away
            s_nxt.state  = s_r.simul ? ST_START : ST_SAMPLE; // [R6]
          end
        end
      end
      default: s_nxt.state = ST_IDLE;
    endcase

    // Channel zero input choice for the coming sequence
    if (s_r.alt && s_nxt.altPhase) begin
      s_nxt.conv.posInput = s_r.secSel; // [R14] [R20]
      s_nxt.conv.altSet   = 1'b1;
    end else begin
      s_nxt.conv.posInput = s_r.scanEn ? s_nxt.scanPtr : s_r.primSel; // [R12]
      s_nxt.conv.altSet   = 1'b0;
    end

    if (s_nxt.state != ST_SAMPLE) begin
      s_nxt.sampling = '0;
    end else if (s_nxt.simul) begin
      // Mode written with the start bit already governs the first sample
      s_nxt.sampling = enMask; // [R6]
    end else begin
      s_nxt.sampling = NUM_CH'(1) << s_nxt.chIdx; // [R6]
    end

    // Read data valid only the cycle after the strobe
    s_nxt.rdData = '0;
    if (busReq.rd) begin
      if (busReq.addr >= ADDR_MEM_BASE) begin
        s_nxt.rdData = memWord; // [R2] [R3]
      end else begin
        case (busReq.addr)
          ADDR_CTL_ONE: begin
            s_nxt.rdData[ONE_FMT_LSB +: 2]  = s_r.fmt;
            s_nxt.rdData[ONE_TRIG_LSB +: 3] = s_r.trig;
            s_nxt.rdData[ONE_SIMUL]         = s_r.simul;
            s_nxt.rdData[ONE_AUTO]          = s_r.autoSmp;
            s_nxt.rdData[ONE_SAMPLE]        = |s_r.sampling; // [R7]
            s_nxt.rdData[ONE_DONE]          = s_r.done;
          end
          ADDR_CTL_TWO: begin
            // Bits 12, 11 and 6 are not stored and read as zero
            s_nxt.rdData[TWO_REF_LSB +: 3]   = s_r.refSel; // [R16]
            s_nxt.rdData[TWO_SCAN]           = s_r.scanEn;
            s_nxt.rdData[TWO_CHCNT_LSB +: 2] = s_r.chCnt;
            s_nxt.rdData[TWO_FILL]           = s_r.split & s_r.fill; // [R19]
            s_nxt.rdData[TWO_IVL_LSB +: 4]   = s_r.ivl;
            s_nxt.rdData[TWO_SPLIT]          = s_r.split;
            s_nxt.rdData[TWO_ALT]            = s_r.alt;
          end
          ADDR_CHAN_SEL: begin
            s_nxt.rdData[SEL_PRIM_LSB +: IN_W] = s_r.primSel;
            s_nxt.rdData[SEL_SEC_LSB +: IN_W]  = s_r.secSel;
          end
          ADDR_PORT_CFG:  s_nxt.rdData = s_r.portCfg;
          ADDR_SCAN_MASK: s_nxt.rdData = s_r.scanMask;
          default:        s_nxt.rdData = '0;
        endcase
      end
    end

    // Splitting restarts the fill at the lower half
    if (wrTwo && busReq.wdata[TWO_SPLIT] != s_r.split) begin
      s_nxt.fill  = 1'b0;
      s_nxt.wrPtr = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  sac_result_mem #(
    .DEPTH (MEM_DEPTH),
    .AW    (PTR_W)
  ) u_mem (
    .core_clk (core_clk),
    .reset    (reset),
    .wrEn     (memWr),
    .wrAddr   (s_r.wrPtr),
    .wrData   (convRsp.result),
    .rdAddr   (busReq.addr[PTR_W-1:0]),
    .rdFormat (s_r.fmt),
    .rdWord   (memWord)
  );

  assign rdData        = s_r.rdData;
  assign convReq       = s_r.conv;
  assign sampleHold    = s_r.sampling;
  assign refHighExt    = !s_r.refSel[2] && s_r.refSel[0]; // [R11]
  assign refLowExt     = !s_r.refSel[2] && s_r.refSel[1]; // [R11]
  assign analogPinMode = s_r.portCfg;
  assign seqIrq        = s_r.irq;
endmodule

// file: design/sac_pkg.sv
// Shared constants, register layout and carrier types of the converter sequencer
package sac_pkg;
  localparam int ADDR_W    = 5;
  localparam int DATA_W    = 16;
  localparam int RES_W     = 10;
  localparam int PAD_W     = DATA_W - RES_W;
  localparam int NUM_CH    = 4;
  localparam int MEM_DEPTH = 16;
  localparam int PTR_W     = 4;
  localparam int IN_W      = 4;
  localparam int NUM_PINS  = 16;

  // Register word addresses
  localparam logic [ADDR_W-1:0] ADDR_CTL_ONE   = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTL_TWO   = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_SEL  = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_PORT_CFG  = 5'h03;
  localparam logic [ADDR_W-1:0] ADDR_SCAN_MASK = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_MEM_BASE  = 5'h10;

  // converter_control_one fields
  localparam int ONE_DONE     = 0;
  localparam int ONE_SAMPLE   = 1;
  localparam int ONE_AUTO     = 2;
  localparam int ONE_SIMUL    = 3;
  localparam int ONE_TRIG_LSB = 5;
  localparam int ONE_FMT_LSB  = 8;

  // converter_control_two fields
  localparam int TWO_ALT       = 0;
  localparam int TWO_SPLIT     = 1;
  localparam int TWO_IVL_LSB   = 2;
  localparam int TWO_FILL      = 7;
  localparam int TWO_CHCNT_LSB = 8;
  localparam int TWO_SCAN      = 10;
  localparam int TWO_REF_LSB   = 13;

  // input_channel_select fields
  localparam int SEL_PRIM_LSB = 0;
  localparam int SEL_SEC_LSB  = 8;

  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [1:0] CHCNT_ONE   = 2'h0;
  localparam logic [1:0] CHCNT_TWO   = 2'h1;

  localparam logic [1:0] FMT_INT      = 2'h0;
  localparam logic [1:0] FMT_SINT     = 2'h1;
  localparam logic [1:0] FMT_FRAC     = 2'h2;
  localparam logic [1:0] FMT_SFRAC    = 2'h3;

  // Timed sampling window for later channels in sequential mode
  localparam int CLK_PERIOD_NS  = 20;
  localparam int SEQ_SAMPLE_NS  = 100;
  localparam int SEQ_SAMPLE_CYC = (SEQ_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SMP_CNT_W      = 8;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_START, ST_WAIT} sac_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sac_bus_req_t;

  typedef struct packed {
    logic            start;
    logic [1:0]      channel;
    logic [IN_W-1:0] posInput;
    logic            altSet;
  } sac_conv_req_t;

  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] result;
  } sac_conv_rsp_t;
endpackage

// file: design/sac_result_mem.sv
// Sixteen-word result memory with read-time output formatting
`timescale 1ns/1ps
module sac_result_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic                     wrEn,
  input  wire logic [AW-1:0]            wrAddr,
  input  wire logic [sac_pkg::RES_W-1:0] wrData,
  input  wire logic [AW-1:0]            rdAddr,
  input  wire logic [1:0]               rdFormat,
  output logic      [sac_pkg::DATA_W-1:0] rdWord
);
  import sac_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][RES_W-1:0] words;
  } sac_mem_state_t;

  sac_mem_state_t mem_r;
  sac_mem_state_t mem_nxt;
  logic [RES_W-1:0] raw;

  always_comb begin
    mem_nxt = mem_r;
    if (wrEn) begin
      mem_nxt.words[wrAddr] = wrData; // [R1]
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mem_r <= '0;
    end else begin
      mem_r <= mem_nxt;
    end
  end

  // Stored raw; alignment chosen only when read
  assign raw = mem_r.words[rdAddr];
  always_comb begin
    case (rdFormat) // [R3]
      FMT_INT:   rdWord = {{PAD_W{1'b0}}, raw};
      FMT_SINT:  rdWord = {{PAD_W{~raw[RES_W-1]}}, ~raw[RES_W-1], raw[RES_W-2:0]};
      FMT_FRAC:  rdWord = {raw, {PAD_W{1'b0}}};
      FMT_SFRAC: rdWord = {~raw[RES_W-1], raw[RES_W-2:0], {PAD_W{1'b0}}};
      default:   rdWord = '0;
    endcase
  end
endmodule

// file: bench/sac_monitor.sv
// Port-level checks of the converter sequencer, bound to its top module
`timescale 1ns/1ps
module sac_monitor (
  input wire logic                          core_clk,
  input wire logic                          reset,
  input wire sac_pkg::sac_bus_req_t         busReq,
  input wire logic [sac_pkg::DATA_W-1:0]    rdData,
  input wire sac_pkg::sac_conv_req_t        convReq,
  input wire sac_pkg::sac_conv_rsp_t        convRsp,
  input wire logic [sac_pkg::NUM_CH-1:0]    sampleHold,
  input wire logic                          refHighExt,
  input wire logic                          refLowExt,
  input wire logic [sac_pkg::NUM_PINS-1:0]  analogPinMode,
  input wire logic                          seqIrq
);
  import sac_pkg::*;
  logic [2:0]          refSel_r;
  logic [NUM_PINS-1:0] portCfg_r;
  // Shadow copies of what software last wrote
  always_ff @(posedge core_clk) begin
    if (reset) begin
      refSel_r <= '0;
      portCfg_r <= '0;
    end else if (busReq.wr) begin
      if (busReq.addr == ADDR_CTL_TWO) refSel_r <= busReq.wdata[TWO_REF_LSB +: 3];
      if (busReq.addr == ADDR_PORT_CFG) portCfg_r <= busReq.wdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_endWrite;
    sampleHold[0] && busReq.wr && busReq.addr == ADDR_CTL_ONE && !busReq.wdata[ONE_SAMPLE]
      && busReq.wdata[ONE_TRIG_LSB +: 3] == TRIG_MANUAL;
  endsequence
  sequence s_startCh0;
    convReq.start && convReq.channel == 2'h0 && sampleHold == '0;
  endsequence
  // One cycle in the start state, then the registered strobe
  property p_manualEnd; s_endWrite |-> ##2 s_startCh0; endproperty
  a_manualEnd: assert property (p_manualEnd) else $error("no start after manual end");
  property p_startPulse; convReq.start |=> !convReq.start; endproperty
  a_startPulse: assert property (p_startPulse) else $error("start too long");
  property p_holdAtStart; convReq.start |-> !sampleHold[convReq.channel]; endproperty
  a_holdAtStart: assert property (p_holdAtStart) else $error("channel sampling at start");
  property p_sampleRead;
    busReq.rd && busReq.addr == ADDR_CTL_ONE |=> rdData[ONE_SAMPLE] == $past(|sampleHold);
  endproperty
  a_sampleRead: assert property (p_sampleRead) else $error("sample bit mismatch");
  property p_irqAfterDone; seqIrq |-> $past(convRsp.done); endproperty
  a_irqAfterDone: assert property (p_irqAfterDone) else $error("irq without done");
  property p_irqPulse; seqIrq |=> !seqIrq; endproperty
  a_irqPulse: assert property (p_irqPulse) else $error("irq too long");
  property p_refHigh; refHighExt == (!refSel_r[2] && refSel_r[0]); endproperty
  a_refHigh: assert property (p_refHigh) else $error("high reference wrong");
  property p_refLow; refLowExt == (!refSel_r[2] && refSel_r[1]); endproperty
  a_refLow: assert property (p_refLow) else $error("low reference wrong");
  property p_pinMode; analogPinMode == portCfg_r; endproperty
  a_pinMode: assert property (p_pinMode) else $error("pin mode wrong");
  property p_ctlTwoRsvd;
    busReq.rd && busReq.addr == ADDR_CTL_TWO |=> rdData[12:11] == 2'h0 && !rdData[6];
  endproperty
  a_ctlTwoRsvd: assert property (p_ctlTwoRsvd) else $error("reserved bits set");
endmodule
bind sac_control sac_monitor u_mon (
  .core_clk(core_clk), .reset(reset), .busReq(busReq), .rdData(rdData), .convReq(convReq),
  .convRsp(convRsp), .sampleHold(sampleHold), .refHighExt(refHighExt),
  .refLowExt(refLowExt), .analogPinMode(analogPinMode), .seqIrq(seqIrq));

// file: bench/tb_sac_control.sv
// Self-checking bench of the converter sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module tb_sac_control;
  import sac_pkg::*;
  logic                core_clk;
  logic                reset;
  sac_bus_req_t        busReq;
  logic [DATA_W-1:0]   rdData;
  sac_conv_req_t       convReq;
  sac_conv_rsp_t       convRsp;
  logic [NUM_CH-1:0]   sampleHold;
  logic                refHighExt;
  logic                refLowExt;
  logic [NUM_PINS-1:0] analogPinMode;
  logic                seqIrq;
  logic [DATA_W-1:0]   d;
  logic [DATA_W-1:0]   two = 16'h0000;
  logic                expAlt = 1'b0;
  logic [IN_W-1:0]     expPos = 4'h0;
  int failures = 0;
  int n_checks = 0;
  int nStarts = 0;
  int seen = 0;
  int nIrq = 0;
  int cycles = 0;
  sac_control dut (
    .core_clk(core_clk), .reset(reset), .busReq(busReq), .rdData(rdData), .convReq(convReq),
    .convRsp(convRsp), .sampleHold(sampleHold), .refHighExt(refHighExt),
    .refLowExt(refLowExt), .analogPinMode(analogPinMode), .seqIrq(seqIrq));
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (convReq.start === 1'b1) nStarts++;
    if (seqIrq === 1'b1) nIrq++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge core_clk);
    busReq <= '{a, v, 1'b1, 1'b0};
    @(posedge core_clk);
    busReq.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    busReq <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    #1;
    d = rdData;
  endtask
  // Far-side converter core: answers three cycles after each start
  task automatic core(input logic [RES_W-1:0] r, input logic [1:0] ch);
    for (int i = 0; i < 60 && nStarts == seen; i++) @(posedge core_clk) #1;
    `CHK(nStarts, seen + 1)
    seen++;
    `CHK(convReq.channel, ch)
    if (ch == 2'h0) begin
      `CHK(convReq.altSet, expAlt)
      `CHK(convReq.posInput, expPos)
    end
    repeat (2) @(posedge core_clk);
    convRsp <= '{1'b1, r};
    @(posedge core_clk);
    convRsp <= '{1'b0, ~r};
    #1;
  endtask
  function automatic logic [15:0] fmtWord(input logic [1:0] f, input logic [9:0] r);
    case (f)
      FMT_INT: return {6'h00, r};
      FMT_SINT: return {{7{~r[9]}}, r[8:0]};
      FMT_FRAC: return {r, 6'h00};
      default: return {~r[9], r[8:0], 6'h00};
    endcase
  endfunction
  task automatic run_seq(input int n, input logic s, input logic [RES_W-1:0] base);
    logic [15:0] mode;
    logic [3:0]  expHold;
    mode = {12'h000, s, 3'h0};
    expHold = s ? (4'h1 << n) - 4'h1 : 4'h1;
    wr(ADDR_CTL_TWO, two | (n == 1 ? 16'h0000 : n == 2 ? 16'h0100 : 16'h0200));
    wr(ADDR_CTL_ONE, mode | 16'h0002);
    `CHK(sampleHold, expHold)
    rd(ADDR_CTL_ONE);
    `CHK(d[ONE_SAMPLE], 1'b1)
    // Done written as 1 so this write keeps it; the start write above already cleared it
    wr(ADDR_CTL_ONE, mode | 16'h0001);
    rd(ADDR_CTL_ONE);
    `CHK(d[ONE_DONE], 1'b0)
    for (int c = 0; c < n; c++) begin
      core(RES_W'(base + c), c[1:0]);
      if (c == 0 && n > 1) wr(ADDR_CTL_ONE, mode);
    end
    rd(ADDR_CTL_ONE);
    `CHK(d[ONE_DONE], 1'b1)
    for (int c = 0; c < n; c++) begin
      rd(ADDR_W'(ADDR_MEM_BASE + c));
      `CHK(d, {6'h00, RES_W'(base + c)})
    end
  endtask
  task automatic t_reset();
    for (int a = 0; a < 7; a++) begin
      rd(a < 5 ? ADDR_W'(a) : (a == 5 ? 5'h08 : 5'h1F));
      `CHK(d, 16'h0000)
    end
  endtask
  task automatic t_regs();
    wr(ADDR_PORT_CFG, 16'hA5C3);
    rd(ADDR_PORT_CFG);
    `CHK(d, 16'hA5C3)
    wr(ADDR_SCAN_MASK, 16'h0F0F);
    rd(ADDR_SCAN_MASK);
    `CHK(d, 16'h0F0F)
    wr(ADDR_CTL_TWO, 16'hFFFF);
    rd(ADDR_CTL_TWO);
    `CHK(d, 16'hE73F)
    for (int v = 0; v < 8; v++) begin
      wr(ADDR_CTL_TWO, 16'(v) << TWO_REF_LSB);
      `CHK({refHighExt, refLowExt}, v < 4 ? {v[0], v[1]} : 2'h0)
    end
  endtask
  task automatic t_one();
    run_seq(1, 1'b0, 10'h2A5);
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_CTL_ONE, 16'(f) << ONE_FMT_LSB);
      rd(ADDR_MEM_BASE);
      `CHK(d, fmtWord(f[1:0], 10'h2A5))
    end
    wr(ADDR_CTL_ONE, 16'h0000);
    wr(ADDR_MEM_BASE, 16'hFFFF);
    rd(ADDR_MEM_BASE);
    `CHK(d, 16'h02A5)
  endtask
  task automatic t_alt();
    wr(ADDR_CHAN_SEL, 16'h0903);
    two = 16'h0001;
    for (int k = 0; k < 3; k++) begin
      expAlt = k[0];
      expPos = k[0] ? 4'h9 : 4'h3;
      run_seq(1, 1'b0, 10'h100);
    end
  endtask
  // Non-manual trigger keeps sampling; auto-sample resamples after a sequence
  task automatic t_trig();
    wr(ADDR_CTL_ONE, 16'h0020);
    wr(ADDR_CTL_ONE, 16'h0022);
    wr(ADDR_CTL_ONE, 16'h0020);
    `CHK(sampleHold, 4'h1)
    `CHK(nStarts, seen)
    wr(ADDR_CTL_ONE, 16'h0006);
    wr(ADDR_CTL_ONE, 16'h0004);
    expAlt = 1'b1;
    expPos = 4'h9;
    core(10'h077, 2'h0);
    `CHK(sampleHold, 4'h1)
    expAlt = 1'b0;
    expPos = 4'h3;
    wr(ADDR_CTL_ONE, 16'h0000);
    core(10'h078, 2'h0);
    `CHK(sampleHold, 4'h0)
  endtask
  // Scan of inputs 0, 2 and 5 into a split buffer, interrupt every second sequence
  task automatic t_scan();
    wr(ADDR_SCAN_MASK, 16'h0025);
    wr(ADDR_CTL_TWO, 16'h0406);
    expAlt = 1'b0;
    for (int k = 0; k < 3; k++) begin
      expPos = k == 0 ? 4'h0 : (k == 1 ? 4'h2 : 4'h5);
      wr(ADDR_CTL_ONE, 16'h0002);
      wr(ADDR_CTL_ONE, 16'h0000);
      core(10'h040 + RES_W'(k), 2'h0);
      rd(ADDR_CTL_TWO);
      `CHK(d[TWO_FILL], k > 0)
    end
    rd(ADDR_W'(ADDR_MEM_BASE + 1));
    `CHK(d, 16'h0041)
    rd(ADDR_W'(ADDR_MEM_BASE + 8));
    `CHK(d, 16'h0042)
  endtask
  initial begin
    reset = 1'b1;
    busReq = '0;
    convRsp = '0;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_regs();
    t_one();
    run_seq(2, 1'b1, 10'h155);
    run_seq(4, 1'b1, 10'h3F0);
    run_seq(4, 1'b0, 10'h00A);
    t_alt();
    t_trig();
    t_scan();
    `CHK(nIrq, 10)
    end_of_test();
  end
endmodule
